// [rtl/rwsc_map.svh]
// Offsets, field positions, reset values and timing for the reset and suspend controller
`ifndef RWSC_MAP_SVH
`define RWSC_MAP_SVH

// ==========================================================================
// Clock and times (times in microseconds)
`define RWSC_CLK_MHZ          25
`define RWSC_IGNORE_US        1000
`define RWSC_SEMI_US          95000
`define RWSC_WDT_US           8000
`define RWSC_WDR_US           2000
`define RWSC_WAKE_US          1000
`define RWSC_TMR_W            22

// ==========================================================================
// I/O register offsets
`define RWSC_ADDR_USB_IE      8'h20
`define RWSC_ADDR_WDT_RESTART 8'h26
`define RWSC_ADDR_PSC         8'hff

// ==========================================================================
// Status and control fields and values
`define RWSC_PSC_RUN          0
`define RWSC_PSC_SUSPEND      3
`define RWSC_PSC_POR          4
`define RWSC_PSC_WDR          6
`define RWSC_PSC_POR_VAL      8'h11
`define RWSC_PSC_WDR_VAL      8'h41
`define RWSC_PSC_WDR_KEEP     8'h10
`define RWSC_USB_IE_BUSRST    0
`define RWSC_USB_IE_RST       8'h00
`define RWSC_RESTART_PC       14'h0000
`define RWSC_SP_RESET         8'h00

`endif

// [rtl/rwsc_pkg.sv]
// Types shared by the reset, watchdog and suspend controller
package rwsc_pkg;

  // ========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    S_POR,
    S_IGNORE,
    S_SEMI,
    S_RUN,
    S_WDR,
    S_SUSP,
    S_WAKE
  } rwsc_state_type;

  // ========================================================================
  // Whole state of the top module
  typedef struct packed {
    rwsc_state_type st;
    logic [7:0]     psc;
    logic [7:0]     usb_ie;
    logic           bus_pend;
    logic           defer;
    logic           restart;
    logic [7:0]     rdata;
  } rwsc_top_state_type;

endpackage : rwsc_pkg

// [rtl/rwsc_tmr_if.sv]
// Control and status bundle between the controller and one interval timer
`timescale 1ns/100ps
interface rwsc_tmr_if #(
  parameter int W = 22
);
  logic         clr;
  logic [W-1:0] limit;
  logic         done;

  modport ctrl (output clr, output limit, input done);
  modport tmr  (input clr, input limit, output done);
endinterface : rwsc_tmr_if

// [rtl/rwsc_timer.sv]
// Saturating interval counter used for the sequencer and the watchdog
`timescale 1ns/100ps
module rwsc_timer #(
  parameter int W = 22
) (
  input  wire logic clk,
  input  wire logic nrst,
  rwsc_tmr_if.tmr   tif
);
  import rwsc_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } rwsc_tmr_state_type;

  rwsc_tmr_state_type s_q;
  rwsc_tmr_state_type s_d;

  // ========================================================================
  // Count up to the limit and stay there until cleared
  always_comb begin
    s_d = s_q;
    if (tif.clr) begin
      s_d.cnt = '0;
    end else if (s_q.cnt != tif.limit) begin
      s_d.cnt = s_q.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Level, holds while saturated so a late reader cannot miss it
  assign tif.done = (s_q.cnt == tif.limit);

endmodule : rwsc_timer

// [rtl/rwsc_wake.sv]
// Gathers suspend wake sources into one registered wake request
`timescale 1ns/100ps
module rwsc_wake #(
  parameter int NDOWN = 4
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             gpio_irq,
  input  wire logic             up_active,
  input  wire logic [NDOWN-1:0] down_active,
  output logic                  wake
);
  import rwsc_pkg::*;

  typedef struct packed {
    logic wake;
  } rwsc_wake_state_type;

  rwsc_wake_state_type s_q;
  rwsc_wake_state_type s_d;

  // ========================================================================
  // Only enabled GPIO events and non-idle bus activity count
  always_comb begin
    s_d      = s_q;
    s_d.wake = gpio_irq | up_active | (|down_active);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wake = s_q.wake;

endmodule : rwsc_wake

// [rtl/rwsc_top.sv]
// Reset, watchdog and suspend controller of the USB microcontroller
//
// Summary of operation
// - Any reset restores defaults, clears addresses, interrupts
// - Status bit 4 marks power-on, bit 6 watchdog
// - Fetch restarts from address zero after reset
// - Reset entry pushes nothing onto program stack
// - Power-on reset holds CPU, other blocks run; ftimer_run stays off until S_RUN
// - Good supply and stable oscillator start timer
// - First 1 ms ignores events, then 95 ms
// - Bus reset aborts wait; interrupt stays pending
// - Any write to restart register clears watchdog
// - Watchdog unserviced for 8 ms causes reset
// - Watchdog reset loads status with 010X0001
// - Watchdog reset lasts 2 ms, then restart
// - After watchdog reset, transmitter off, address 0
// - Suspend stops oscillator, PLL, timers, watchdog
// - Only GPIO interrupt or bus activity wakes
// - Oscillator restarts; full operation 1 ms later
// - Next instruction runs before any interrupt service
// - Low supply reasserts power-on reset and sequence
`timescale 1ns/100ps
`include "rwsc_map.svh"
module rwsc_top #(
  parameter int W          = `RWSC_TMR_W,
  parameter int NDOWN      = 4,
  parameter int IGNORE_CYC = `RWSC_IGNORE_US * `RWSC_CLK_MHZ,
  parameter int SEMI_CYC   = `RWSC_SEMI_US * `RWSC_CLK_MHZ,
  parameter int WDT_CYC    = `RWSC_WDT_US * `RWSC_CLK_MHZ,
  parameter int WDR_CYC    = `RWSC_WDR_US * `RWSC_CLK_MHZ,
  parameter int WAKE_CYC   = `RWSC_WAKE_US * `RWSC_CLK_MHZ
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             supply_ok,
  input  wire logic             osc_stable,
  input  wire logic [7:0]       io_addr,
  input  wire logic [7:0]       io_wdata,
  input  wire logic             io_wr,
  input  wire logic             io_rd,
  output logic      [7:0]       io_rdata,
  input  wire logic             usb_bus_reset,
  input  wire logic             bus_reset_ack,
  input  wire logic             int_enabled,
  input  wire logic             cpu_instr_done,
  input  wire logic             usb_addr_nonzero,
  input  wire logic             gpio_wake_irq,
  input  wire logic             usb_up_active,
  input  wire logic [NDOWN-1:0] usb_down_active,
  output logic                  cpu_hold,
  output logic                  cpu_restart,
  output logic      [13:0]      restart_pc,
  output logic      [7:0]       stack_ptr_reset,
  output logic                  stack_push_inhibit,
  output logic                  sys_reset,
  output logic                  usb_addr_clear,
  output logic                  usb_tx_enable,
  output logic                  osc_enable,
  output logic                  pll_enable,
  output logic                  ftimer_run,
  output logic                  irq_inhibit,
  output logic                  bus_reset_irq
);
  import rwsc_pkg::*;

  rwsc_top_state_type s_q;
  rwsc_top_state_type s_d;
  logic               wake;
  logic               wr_psc;
  logic               wr_usb_ie;
  logic               wr_wdt;

  rwsc_tmr_if #(.W(W)) seq_if ();
  rwsc_tmr_if #(.W(W)) wdt_if ();

  // ========================================================================
  // Sub-blocks
  rwsc_timer #(.W(W)) u_seq_tmr (
    .clk  (clk),
    .nrst (nrst),
    .tif  (seq_if)
  );

  rwsc_timer #(.W(W)) u_wdt_tmr (
    .clk  (clk),
    .nrst (nrst),
    .tif  (wdt_if)
  );

  rwsc_wake #(.NDOWN(NDOWN)) u_wake (
    .clk         (clk),
    .nrst        (nrst),
    .gpio_irq    (gpio_wake_irq),
    .up_active   (usb_up_active),
    .down_active (usb_down_active),
    .wake        (wake)
  );

  // ========================================================================
  // Register decode; the CPU can only write while it runs
  assign wr_psc    = io_wr && (s_q.st == S_RUN) && (io_addr == `RWSC_ADDR_PSC);
  assign wr_usb_ie = io_wr && (s_q.st == S_RUN) && (io_addr == `RWSC_ADDR_USB_IE);
  assign wr_wdt    = io_wr && (s_q.st == S_RUN) && (io_addr == `RWSC_ADDR_WDT_RESTART);

  // Watchdog only runs with the CPU; held clear in every other state
  assign wdt_if.clr   = (s_q.st != S_RUN) || wr_wdt;
  assign wdt_if.limit = WDT_CYC[W-1:0];

  // Sequencer interval chosen by the current phase
  always_comb begin
    case (s_q.st)
      S_IGNORE: seq_if.limit = IGNORE_CYC[W-1:0];
      S_SEMI:   seq_if.limit = SEMI_CYC[W-1:0];
      S_WDR:    seq_if.limit = WDR_CYC[W-1:0];
      S_WAKE:   seq_if.limit = WAKE_CYC[W-1:0];
      default:  seq_if.limit = IGNORE_CYC[W-1:0];
    endcase
  end

  // Restart the interval on every phase change; wake waits for the oscillator
  always_comb begin
    seq_if.clr = (s_d.st != s_q.st) || (s_q.st == S_POR) || (s_q.st == S_RUN) ||
                 (s_q.st == S_SUSP) || ((s_q.st == S_WAKE) && !osc_stable);
  end

  // ========================================================================
  // Sequencer and register file next state
  always_comb begin
    s_d         = s_q;
    s_d.restart = 1'b0;

    // Software writes; cause flags stay as they are otherwise
    if (wr_psc) begin
      s_d.psc = io_wdata;
    end
    if (wr_usb_ie) begin
      s_d.usb_ie = io_wdata;
    end

    // Acknowledge first so a new bus reset in the same cycle wins
    if (bus_reset_ack) begin
      s_d.bus_pend = 1'b0;
    end
    if (cpu_instr_done) begin
      s_d.defer = 1'b0;
    end

    case (s_q.st)
      S_POR: begin
        if (supply_ok && osc_stable) begin
          s_d.st = S_IGNORE;
        end
      end
      S_IGNORE: begin
        // Bus reset deliberately not looked at here
        if (seq_if.done) begin
          s_d.st = S_SEMI;
        end
      end
      S_SEMI: begin
        if (usb_bus_reset) begin
          s_d.st       = S_RUN;
          s_d.restart  = 1'b1;
          s_d.bus_pend = 1'b1;
        end else if (seq_if.done) begin
          s_d.st      = S_RUN;
          s_d.restart = 1'b1;
        end
      end
      S_RUN: begin
        if (usb_bus_reset) begin
          s_d.bus_pend = 1'b1;
        end
        if (wdt_if.done) begin
          s_d.st     = S_WDR;
          s_d.psc    = `RWSC_PSC_WDR_VAL | (s_q.psc & `RWSC_PSC_WDR_KEEP);
          s_d.usb_ie = `RWSC_USB_IE_RST;
          s_d.defer  = 1'b0;
        end else if (wr_psc && io_wdata[`RWSC_PSC_SUSPEND]) begin
          s_d.st = S_SUSP;
        end
      end
      S_WDR: begin
        if (seq_if.done) begin
          s_d.st      = S_RUN;
          s_d.restart = 1'b1;
        end
      end
      S_SUSP: begin
        // Without the run bit the part stays asleep
        if (wake && s_q.psc[`RWSC_PSC_RUN]) begin
          s_d.st = S_WAKE;
        end
      end
      S_WAKE: begin
        if (osc_stable && seq_if.done) begin
          s_d.st                    = S_RUN;
          s_d.defer                 = 1'b1;
          s_d.psc[`RWSC_PSC_SUSPEND] = 1'b0;
        end
      end
      default: begin
        s_d.st = S_POR;
      end
    endcase

    // Read data captured on the strobe; unmapped and write-only read zero
    if (io_rd) begin
      case (io_addr)
        `RWSC_ADDR_USB_IE: s_d.rdata = s_q.usb_ie;
        `RWSC_ADDR_PSC:    s_d.rdata = s_q.psc;
        default:           s_d.rdata = 8'h00;
      endcase
    end

    // Supply loss overrides everything and restarts the whole sequence
    if (!supply_ok) begin
      s_d.st       = S_POR;
      s_d.psc      = `RWSC_PSC_POR_VAL;
      s_d.usb_ie   = `RWSC_USB_IE_RST;
      s_d.bus_pend = 1'b0;
      s_d.defer    = 1'b0;
      s_d.restart  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q.st       <= S_POR;
      s_q.psc      <= `RWSC_PSC_POR_VAL;
      s_q.usb_ie   <= `RWSC_USB_IE_RST;
      s_q.bus_pend <= 1'b0;
      s_q.defer    <= 1'b0;
      s_q.restart  <= 1'b0;
      s_q.rdata    <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // Outputs to the CPU core, USB function and clock blocks
  assign io_rdata           = s_q.rdata;
  assign cpu_hold           = (s_q.st != S_RUN);
  assign cpu_restart        = s_q.restart;
  assign restart_pc         = `RWSC_RESTART_PC;
  assign stack_ptr_reset    = `RWSC_SP_RESET;
  assign sys_reset          = (s_q.st == S_POR) || (s_q.st == S_WDR);
  assign stack_push_inhibit = s_q.restart || sys_reset;
  assign usb_addr_clear     = sys_reset;
  assign usb_tx_enable      = (s_q.st == S_RUN) && usb_addr_nonzero;
  assign osc_enable         = (s_q.st != S_SUSP);
  assign pll_enable         = (s_q.st != S_SUSP);
  assign ftimer_run         = (s_q.st == S_RUN);
  assign irq_inhibit        = s_q.defer || cpu_hold;
  assign bus_reset_irq      = s_q.bus_pend && s_q.usb_ie[`RWSC_USB_IE_BUSRST] &&
                              int_enabled && !irq_inhibit;

  // ========================================================================
  // Assertions
  default clocking rwsc_cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence rwsc_wdt_expire;
    (s_q.st == S_RUN) && wdt_if.done && supply_ok;
  endsequence

  sequence rwsc_wdr_entered;
    (s_q.st == S_WDR) && sys_reset && (s_q.usb_ie == 8'h00);
  endsequence

  a_supply_loss_por: assert property (!supply_ok |=> (s_q.st == S_POR) && sys_reset
    && (s_q.psc == 8'h11)) else $error("supply loss did not restart power-on");

  a_watchdog_fires: assert property (rwsc_wdt_expire |=> rwsc_wdr_entered)
    else $error("watchdog expiry did not reset");

  a_wdr_pattern: assert property ((s_q.st == S_WDR) |-> (s_q.psc[7:5] == 3'b010)
    && (s_q.psc[3:0] == 4'h1)) else $error("watchdog status pattern wrong");

  a_wdr_release: assert property (((s_q.st == S_WDR) && seq_if.done && supply_ok) |=>
    (s_q.st == S_RUN) && cpu_restart && stack_push_inhibit && (restart_pc == 14'h0000))
    else $error("watchdog reset did not end in a clean restart");

  a_wdt_kick_clears: assert property ((wr_wdt && supply_ok) |=> !wdt_if.done
    && (s_q.st == S_RUN)) else $error("restart write did not clear watchdog");

  a_ignore_window: assert property (((s_q.st == S_IGNORE) && !seq_if.done && supply_ok)
    |=> (s_q.st == S_IGNORE) && !s_q.bus_pend) else $error("event taken in first interval");

  a_bus_reset_abort: assert property (((s_q.st == S_SEMI) && usb_bus_reset && supply_ok)
    |=> (s_q.st == S_RUN) && cpu_restart && s_q.bus_pend && !bus_reset_irq)
    else $error("bus reset did not abort the wait");

  a_semi_cpu_held: assert property (((s_q.st == S_IGNORE) || (s_q.st == S_SEMI)) |->
    cpu_hold && osc_enable && !sys_reset) else $error("cpu not held in semi-suspend");

  a_suspend_off: assert property ((s_q.st == S_SUSP) |-> !osc_enable && !pll_enable
    && !ftimer_run && wdt_if.clr) else $error("block left running in suspend");

  a_wake_sources: assert property (((s_q.st == S_SUSP) && !wake && supply_ok) |=>
    (s_q.st == S_SUSP)) else $error("suspend left without wake source");

  a_wake_defer: assert property ($rose(s_q.defer) |-> (s_q.st == S_RUN) && irq_inhibit
    && !bus_reset_irq) else $error("interrupt not deferred after wake");

  a_flags_hold: assert property (((s_q.st == S_RUN) && !wr_psc && !wdt_if.done && supply_ok)
    |=> $stable(s_q.psc[6:4])) else $error("reset cause flags changed");

endmodule : rwsc_top

// [testbench/rwsc_cpu_model.sv]
// Behavioural CPU core: retires instructions and acknowledges the bus-reset interrupt
`timescale 1ns/100ps
module rwsc_cpu_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic slow,
  input  wire logic cpu_hold,
  input  wire logic bus_reset_irq,
  output logic      cpu_instr_done,
  output logic      bus_reset_ack
);
  logic [3:0] gap_q;
  logic [3:0] wait_q;

  // ========================================================================
  // One instruction every fourth running cycle; the handler never returns
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap_q          <= 4'h0;
      cpu_instr_done <= 1'b0;
    end else begin
      gap_q          <= cpu_hold ? 4'h0 : gap_q + 4'h1;
      cpu_instr_done <= !cpu_hold && (gap_q[1:0] == 2'h3);
    end
  end

  // Slow mode delays the acknowledge so the request is seen standing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_q        <= 4'h0;
      bus_reset_ack <= 1'b0;
    end else begin
      bus_reset_ack <= bus_reset_irq && !bus_reset_ack && (wait_q >= (slow ? 4'h7 : 4'h0));
      wait_q        <= (bus_reset_irq && !bus_reset_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : rwsc_cpu_model

// [testbench/rwsc_top_bench.sv]
// Self-checking bench for the reset, watchdog and suspend controller
`timescale 1ns/100ps
`include "rwsc_map.svh"
module rwsc_top_bench;
  import rwsc_pkg::*;
  localparam int IGN  = 10;
  localparam int SEMI = 30;
  localparam int WDT  = 40;
  localparam int WATCHDOG_RESET_FLAG  = 20;
  localparam int WAKE = 16;
  logic        clk, nrst, supply_ok, osc_stable, io_wr, io_rd, usb_bus_reset, int_enabled;
  logic        usb_addr_nonzero, gpio_wake_irq, usb_up_active, slow;
  logic [7:0]  io_addr, io_wdata, io_rdata, stack_ptr_reset, d;
  logic [3:0]  usb_down_active;
  logic [13:0] restart_pc;
  logic        cpu_hold, cpu_restart, stack_push_inhibit, sys_reset, usb_addr_clear;
  logic        usb_tx_enable, osc_enable, pll_enable, ftimer_run, irq_inhibit;
  logic        bus_reset_irq, cpu_instr_done, bus_reset_ack;
  int          fail_count, tests_run, n, m;
  integer      seed;

  rwsc_top #(.IGNORE_CYC(IGN), .SEMI_CYC(SEMI), .WDT_CYC(WDT), .WDR_CYC(WATCHDOG_RESET_FLAG),
    .WAKE_CYC(WAKE)) rwsc_top_i (.clk(clk), .nrst(nrst), .supply_ok(supply_ok),
    .osc_stable(osc_stable), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
    .io_rd(io_rd), .io_rdata(io_rdata), .usb_bus_reset(usb_bus_reset),
    .bus_reset_ack(bus_reset_ack), .int_enabled(int_enabled),
    .cpu_instr_done(cpu_instr_done), .usb_addr_nonzero(usb_addr_nonzero),
    .gpio_wake_irq(gpio_wake_irq), .usb_up_active(usb_up_active),
    .usb_down_active(usb_down_active), .cpu_hold(cpu_hold), .cpu_restart(cpu_restart),
    .restart_pc(restart_pc), .stack_ptr_reset(stack_ptr_reset),
    .stack_push_inhibit(stack_push_inhibit), .sys_reset(sys_reset),
    .usb_addr_clear(usb_addr_clear), .usb_tx_enable(usb_tx_enable),
    .osc_enable(osc_enable), .pll_enable(pll_enable), .ftimer_run(ftimer_run),
    .irq_inhibit(irq_inhibit), .bus_reset_irq(bus_reset_irq));

  rwsc_cpu_model rwsc_cpu_model_i (.clk(clk), .nrst(nrst), .slow(slow),
    .cpu_hold(cpu_hold), .bus_reset_irq(bus_reset_irq),
    .cpu_instr_done(cpu_instr_done), .bus_reset_ack(bus_reset_ack));

  // ========================================================================
  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ========================================================================
  // Helpers
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Every drive lands 1 ns after the rising edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  function automatic logic sel(input int w);
    case (w)
      0: sel = cpu_hold;
      1: sel = sys_reset;
      2: sel = osc_enable;
      default: sel = bus_reset_irq;
    endcase
  endfunction : sel

  // Bounded wait for an output to reach a level; running out ends the run
  task automatic wait_on(input int w, input logic v, input int lim, output int k);
    k = 0;
    while (sel(w) !== v) begin
      if (k == lim) begin
        fail_count++;
        $display("[ERR] wait %0d expected %b seen timeout", w, v);
        stop_test();
      end
      tick(1);
      k++;
    end
  endtask : wait_on

  // Strobes are lowered with an idle cycle after, so none is driven twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    io_addr  = a;
    io_wdata = v;
    io_wr    = 1'b1;
    tick(1);
    io_wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    io_addr = a;
    io_rd   = 1'b1;
    tick(1);
    v     = io_rdata;
    io_rd = 1'b0;
    tick(1);
  endtask : rd

  // Firmware view of the cause: watchdog flag counts only without the power-on flag
  function automatic logic [1:0] cause(input logic [7:0] s);
    cause = s[`RWSC_PSC_POR] ? 2'h1 : (s[`RWSC_PSC_WDR] ? 2'h2 : 2'h0);
  endfunction : cause

  // ========================================================================
  // Main sequence
  initial begin
    seed = 32'h3039;
    {nrst, supply_ok, osc_stable, io_wr, io_rd, usb_bus_reset, int_enabled} = '0;
    {usb_addr_nonzero, gpio_wake_irq, usb_up_active, slow} = '0;
    {io_addr, io_wdata, usb_down_active} = '0;
    tick(20);
    chk("sys_reset in reset", sys_reset, 1'b1);
    // Read data is held clear under reset, so the cause is read just after release
    nrst = 1'b1;
    rd(`RWSC_ADDR_PSC, d);
    chk("status in reset", d, `RWSC_PSC_POR_VAL);
    tick(3);
    chk("hold without supply", cpu_hold, 1'b1);
    supply_ok = 1'b1;
    tick(3);
    chk("hold without oscillator", sys_reset, 1'b1);
    osc_stable = 1'b1;
    tick(IGN / 2);
    usb_bus_reset = 1'b1;
    tick(2);
    usb_bus_reset = 1'b0;
    wait_on(0, 1'b0, IGN + SEMI + 6, n);
    n = n + IGN / 2 + 2;
    chk("semi-suspend length", (n >= IGN + SEMI - 1) && (n <= IGN + SEMI + 4), 1'b1);
    chk("restart pulse", cpu_restart, 1'b1);
    chk("restart pc", restart_pc, `RWSC_RESTART_PC);
    chk("stack reset", stack_ptr_reset, `RWSC_SP_RESET);
    chk("no push", stack_push_inhibit, 1'b1);
    rd(`RWSC_ADDR_USB_IE, d);
    chk("usb_ie default", d, `RWSC_USB_IE_RST);
    // Unmask so a bus reset wrongly taken in the first interval would show
    int_enabled = 1'b1;
    wr(`RWSC_ADDR_USB_IE, 8'h01);
    chk("early bus reset ignored", bus_reset_irq, 1'b0);
    // Supply dip during run restarts the sequence; bus reset then cuts it short
    wr(`RWSC_ADDR_PSC, 8'h01);
    supply_ok = 1'b0;
    tick(1);
    chk("dip reset", sys_reset, 1'b1);
    rd(`RWSC_ADDR_PSC, d);
    chk("dip status", d, `RWSC_PSC_POR_VAL);
    supply_ok = 1'b1;
    slow      = 1'b1;
    tick(IGN + 6);
    chk("held in semi", cpu_hold, 1'b1);
    usb_bus_reset = 1'b1;
    wait_on(0, 1'b0, 3, n);
    usb_bus_reset = 1'b0;
    int_enabled   = 1'b1;
    tick(2);
    chk("pending masked", bus_reset_irq, 1'b0);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) wr(`RWSC_ADDR_USB_IE, 8'h01);
      else usb_bus_reset = 1'b1;
      wait_on(3, 1'b1, 4, n);
      usb_bus_reset = 1'b0;
      slow          = 1'b0;
      wait_on(3, 1'b0, 12, n);
    end
    // Watchdog serviced at random spacing, then left to expire
    usb_addr_nonzero = 1'b1;
    tick(1);
    chk("tx on in run", usb_tx_enable, 1'b1);
    wr(`RWSC_ADDR_PSC, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr(`RWSC_ADDR_WDT_RESTART, 8'($random(seed)));
      tick(4 + {$random(seed)} % (WDT - 12));
      chk("no watchdog while serviced", sys_reset, 1'b0);
    end
    wr(`RWSC_ADDR_WDT_RESTART, 8'h00);
    wait_on(1, 1'b1, WDT + 4, m);
    chk("watchdog period", m >= WDT - 4, 1'b1);
    chk("tx off in watchdog", usb_tx_enable, 1'b0);
    chk("address clear", usb_addr_clear, 1'b1);
    rd(`RWSC_ADDR_PSC, d);
    chk("watchdog status", d, `RWSC_PSC_WDR_VAL);
    chk("cause watchdog", cause(d), 2'h2);
    wr(`RWSC_ADDR_USB_IE, 8'hff);
    wait_on(0, 1'b0, WATCHDOG_RESET_FLAG + 5, n);
    chk("watchdog length", (n + 4 >= WATCHDOG_RESET_FLAG - 1) && (n + 4 <= WATCHDOG_RESET_FLAG + 3), 1'b1);
    chk("watchdog restart", cpu_restart, 1'b1);
    rd(`RWSC_ADDR_USB_IE, d);
    chk("usb_ie after watchdog", d, `RWSC_USB_IE_RST);
    rd(`RWSC_ADDR_PSC, d);
    chk("flag holds", d, `RWSC_PSC_WDR_VAL);
    // Suspend and wake from every source in turn
    for (int s = 0; s < 6; s++) begin
      wr(`RWSC_ADDR_PSC, 8'h09);
      chk("osc off", osc_enable, 1'b0);
      chk("pll off", pll_enable, 1'b0);
      chk("timer off", ftimer_run, 1'b0);
      tick(WDT + 5);
      chk("stays suspended", {cpu_hold, sys_reset}, 2'b10);
      if (s == 0) gpio_wake_irq = 1'b1;
      else if (s == 1) usb_up_active = 1'b1;
      else usb_down_active = 4'h1 << (s - 2);
      if (s == 0) osc_stable = 1'b0;
      tick(2);
      {gpio_wake_irq, usb_up_active, usb_down_active} = '0;
      wait_on(2, 1'b1, 4, n);
      tick(4);
      osc_stable = 1'b1;
      wait_on(0, 1'b0, WAKE + 8, n);
      chk("wake delay", n >= ((s == 0) ? WAKE - 2 : WAKE - 7), 1'b1);
      chk("irq held off", irq_inhibit, 1'b1);
      rd(`RWSC_ADDR_PSC, d);
      chk("suspend bit cleared", d[`RWSC_PSC_SUSPEND], 1'b0);
    end
    // Write-only and unmapped places read zero; status is plain storage
    rd(`RWSC_ADDR_WDT_RESTART, d);
    chk("restart reads zero", d, 8'h00);
    rd(8'h33, d);
    chk("unmapped reads zero", d, 8'h00);
    wr(`RWSC_ADDR_PSC, 8'h51);
    rd(`RWSC_ADDR_PSC, d);
    chk("status written", d, 8'h51);
    chk("cause power-on", cause(d), 2'h1);
    stop_test();
  end
endmodule : rwsc_top_bench
